// file: logic/ipc_defs.svh
// offsets, field positions and reset values of the priority register bank
`ifndef IPC_DEFS_SVH
`define IPC_DEFS_SVH
`define IPC_IDX_DEBUG_A 2'h0
`define IPC_IDX_DEBUG_B 2'h1
`define IPC_IDX_SYSTEM 2'h2
`define IPC_IDX_PORTS 2'h3
`define IPC_RESET_VAL 16'h0000
`define IPC_MASK_DEBUG_A 16'h3C00
`define IPC_MASK_DEBUG_B 16'h003F
`define IPC_MASK_SYSTEM 16'hFFCF
`define IPC_MASK_PORTS 16'hFFFC
`define IPC_NUM_SRC 20
`define IPC_NUM_DEBUG 5
`define IPC_RESP_OKAY 2'b00
`define IPC_RESP_SLVERR 2'b10
`endif

// file: logic/ipc_pkg.sv
// types of the priority register bank
package ipc_pkg;
    typedef enum logic [1:0] {
        FIELD_OFF = 2'b00,
        FIELD_LOW = 2'b01,
        FIELD_MID = 2'b10,
        FIELD_HIGH = 2'b11
    } ipc_field_t;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } ipc_wr_state_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } ipc_rd_state_t;
endpackage : ipc_pkg

// file: logic/ipc_priority_regs.sv
// priority register bank with axi4-lite slave and per-source decode
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ipc_defs.svh"

module ipc_priority_regs (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [19:0] srcPending,
    output logic [19:0] srcEnable,
    output logic [39:0] srcLevel,
    output logic [19:0] srcRequest
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // byte address -> register index; upper bits must be zero to hit
    function automatic logic addr_hit(input logic [31:0] a);
        addr_hit = (a[31:4] == 28'h000_0000) && (a[1:0] == 2'b00);
    endfunction : addr_hit

    function automatic logic [15:0] reg_mask(input logic [1:0] idx);
        if (idx == `IPC_IDX_DEBUG_A) begin
            reg_mask = `IPC_MASK_DEBUG_A;
        end else if (idx == `IPC_IDX_DEBUG_B) begin
            reg_mask = `IPC_MASK_DEBUG_B;
        end else if (idx == `IPC_IDX_SYSTEM) begin
            reg_mask = `IPC_MASK_SYSTEM;
        end else begin
            reg_mask = `IPC_MASK_PORTS;
        end
    endfunction : reg_mask

    // level from a field; debug sources sit one level higher
    function automatic logic [1:0] field_level(input logic [1:0] f, input logic dbg);
        if (dbg) begin
            field_level = f;
        end else begin
            field_level = f - 2'b01;
        end
    endfunction : field_level

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [15:0] prio_q [4];
    logic [15:0] prio_d [4];

    ////////////////////////////////////////////////////////////////////////////
    // write channel

    ipc_pkg::ipc_wr_state_t wrState_q, wrState_d;
    logic [1:0] bresp_q, bresp_d;
    logic wrFire;
    logic [1:0] wrIdx;
    logic [15:0] wrBits;

    // both address and data must be present; taken together in one cycle
    assign wrFire = (wrState_q == ipc_pkg::WR_IDLE) && s_axi_awvalid && s_axi_wvalid;
    assign s_axi_awready = wrFire;
    assign s_axi_wready = wrFire;
    assign s_axi_bvalid = (wrState_q == ipc_pkg::WR_RESP);
    assign s_axi_bresp = bresp_q;
    assign wrIdx = s_axi_awaddr[3:2];
    assign wrBits = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    always_comb begin
        wrState_d = wrState_q;
        bresp_d = bresp_q;
        for (int i = 0; i < 4; i++) begin
            prio_d[i] = prio_q[i];
        end
        case (wrState_q)
            ipc_pkg::WR_IDLE: begin
                if (wrFire) begin
                    wrState_d = ipc_pkg::WR_RESP;
                    if (addr_hit(s_axi_awaddr)) begin
                        bresp_d = `IPC_RESP_OKAY;
                        // reserved bits stay zero whatever is written
                        prio_d[wrIdx] = (prio_q[wrIdx] & ~(wrBits & reg_mask(wrIdx)))
                            | (s_axi_wdata[15:0] & wrBits & reg_mask(wrIdx));
                    end else begin
                        bresp_d = `IPC_RESP_SLVERR;
                    end
                end
            end
            ipc_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    wrState_d = ipc_pkg::WR_IDLE;
                end
            end
            default: begin
                wrState_d = ipc_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wrState_q <= ipc_pkg::WR_IDLE;
            bresp_q <= `IPC_RESP_OKAY;
            for (int i = 0; i < 4; i++) begin
                prio_q[i] <= `IPC_RESET_VAL;
            end
        end else begin
            wrState_q <= wrState_d;
            bresp_q <= bresp_d;
            for (int i = 0; i < 4; i++) begin
                prio_q[i] <= prio_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel

    ipc_pkg::ipc_rd_state_t rdState_q, rdState_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    assign s_axi_arready = (rdState_q == ipc_pkg::RD_IDLE);
    assign s_axi_rvalid = (rdState_q == ipc_pkg::RD_RESP);
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        rdState_d = rdState_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        case (rdState_q)
            ipc_pkg::RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rdState_d = ipc_pkg::RD_RESP;
                    if (addr_hit(s_axi_araddr)) begin
                        rresp_d = `IPC_RESP_OKAY;
                        rdata_d = {16'h0000, prio_q[s_axi_araddr[3:2]]};
                    end else begin
                        rresp_d = `IPC_RESP_SLVERR;
                        rdata_d = 32'h0000_0000;
                    end
                end
            end
            ipc_pkg::RD_RESP: begin
                if (s_axi_rready) begin
                    rdState_d = ipc_pkg::RD_IDLE;
                end
            end
            default: begin
                rdState_d = ipc_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdState_q <= ipc_pkg::RD_IDLE;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `IPC_RESP_OKAY;
        end else begin
            rdState_q <= rdState_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-source decode; sources 15-19 are debug, 0-14 system

    logic [39:0] fields;

    // order: breakpoint0, step counter, rx full, tx empty, trace,
    // flash empty, flash done, flash error, lock, low voltage, ext B, ext A,
    // port D, E, F, msg buffer, wake-up, msg error, bus-off, (pad to 20: none)
    assign fields = {
        prio_q[0][13:12], prio_q[0][11:10],
        prio_q[1][5:4], prio_q[1][3:2], prio_q[1][1:0],
        prio_q[2][15:14], prio_q[2][13:12], prio_q[2][11:10], prio_q[2][9:8],
        prio_q[2][7:6], prio_q[2][3:2], prio_q[2][1:0],
        prio_q[3][15:14], prio_q[3][13:12], prio_q[3][11:10], prio_q[3][9:8],
        prio_q[3][7:6],
        prio_q[3][5:4], prio_q[3][3:2],
        2'b00
    };

    // combinational so the decode follows the register on the write edge
    always_comb begin
        for (int s = 0; s < `IPC_NUM_SRC; s++) begin
            srcEnable[19 - s] = (fields[39 - 2*s -: 2] != ipc_pkg::FIELD_OFF);
            srcLevel[2*(19 - s) +: 2] = field_level(fields[39 - 2*s -: 2],
                s < `IPC_NUM_DEBUG);
        end
    end

    // last slot is a spare with no field: permanently disabled
    assign srcRequest = srcPending & srcEnable;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (prio_q[0] & ~`IPC_MASK_DEBUG_A) == 16'h0000
            && (prio_q[1] & ~`IPC_MASK_DEBUG_B) == 16'h0000
            && (prio_q[2] & ~`IPC_MASK_SYSTEM) == 16'h0000
            && (prio_q[3] & ~`IPC_MASK_PORTS) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_reset_clear;
        @(posedge sys_clk) !rst_b |=> prio_q[2] == 16'h0000 && srcEnable == 20'h0_0000;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset not clear");

    property p_fields_off;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(rst_b) |-> srcRequest == 20'h0_0000;
    endproperty
    a_fields_off: assert property (p_fields_off) else $error("source on after reset");

    property p_debug_level;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[19] |-> srcLevel[39:38] == prio_q[0][13:12] && srcLevel[39:38] != 2'b00;
    endproperty
    a_debug_level: assert property (p_debug_level) else $error("debug level wrong");

    property p_system_level;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[8] |-> srcLevel[17:16] == prio_q[2][1:0] - 2'b01 && srcLevel[17:16] != 2'b11;
    endproperty
    a_system_level: assert property (p_system_level) else $error("system level wrong");

    property p_step_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[18] == (prio_q[0][11:10] != 2'b00);
    endproperty
    a_step_field: assert property (p_step_field) else $error("step field misplaced");

    property p_trace_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[15] == (prio_q[1][1:0] != 2'b00);
    endproperty
    a_trace_field: assert property (p_trace_field) else $error("trace field misplaced");

    property p_lock_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[11] == (prio_q[2][9:8] != 2'b00);
    endproperty
    a_lock_field: assert property (p_lock_field) else $error("lock field misplaced");

    property p_lowv_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[10] == (prio_q[2][7:6] != 2'b00);
    endproperty
    a_lowv_field: assert property (p_lowv_field) else $error("low voltage misplaced");

    property p_port_d_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[7] == (prio_q[3][15:14] != 2'b00);
    endproperty
    a_port_d_field: assert property (p_port_d_field) else $error("port d misplaced");

    property p_busoff_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[1] == (prio_q[3][3:2] != 2'b00) && !srcEnable[0];
    endproperty
    a_busoff_field: assert property (p_busoff_field) else $error("bus-off misplaced");

    sequence s_write_reg3;
        wrFire && addr_hit(s_axi_awaddr) && wrIdx == 2'h3 && s_axi_wstrb[1];
    endsequence
    property p_write_updates;
        @(posedge sys_clk) disable iff (!rst_b)
        s_write_reg3 |=> srcEnable[7] == ($past(s_axi_wdata[15:14]) != 2'b00);
    endproperty
    a_write_updates: assert property (p_write_updates) else $error("enable not updated");

    property p_no_request_off;
        @(posedge sys_clk) disable iff (!rst_b)
        !srcEnable[19] |-> !srcRequest[19];
    endproperty
    a_no_request_off: assert property (p_no_request_off) else $error("disabled source fired");

    property p_rx_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[17] == (prio_q[1][5:4] != 2'b00);
    endproperty
    a_rx_field: assert property (p_rx_field) else $error("rx full misplaced");

    property p_flash_empty_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[14] == (prio_q[2][15:14] != 2'b00);
    endproperty
    a_flash_empty_field: assert property (p_flash_empty_field) else $error("flash misplaced");

    property p_ext_b_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[9] == (prio_q[2][3:2] != 2'b00);
    endproperty
    a_ext_b_field: assert property (p_ext_b_field) else $error("ext b misplaced");

    property p_wakeup_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[3] == (prio_q[3][7:6] != 2'b00);
    endproperty
    a_wakeup_field: assert property (p_wakeup_field) else $error("wake-up misplaced");

    property p_msg_error_field;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[2] == (prio_q[3][5:4] != 2'b00);
    endproperty
    a_msg_error_field: assert property (p_msg_error_field) else $error("msg error misplaced");

    property p_trace_level;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[15] |-> srcLevel[31:30] == prio_q[1][1:0] && srcLevel[31:30] != 2'b00;
    endproperty
    a_trace_level: assert property (p_trace_level) else $error("trace level wrong");

    property p_busoff_level;
        @(posedge sys_clk) disable iff (!rst_b)
        srcEnable[1] |-> srcLevel[3:2] == prio_q[3][3:2] - 2'b01 && srcLevel[3:2] != 2'b11;
    endproperty
    a_busoff_level: assert property (p_busoff_level) else $error("bus-off level wrong");

    // upper half of a read word has no storage behind it
    property p_read_upper_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits set");

endmodule : ipc_priority_regs
`default_nettype wire

// file: sim/ipc_arb_model.sv
// far-side model: pending sources and request check
`timescale 1ns/10ps
`default_nettype none
module ipc_arb_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [19:0] srcEnable,
    input wire logic [19:0] srcRequest,
    output logic [19:0] srcPending,
    output logic [15:0] badCount
);
    // pending flips every cycle so a stale request cannot pass
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            srcPending <= 20'h5_5555;
            badCount <= 16'h0000;
        end else begin
            srcPending <= ~srcPending;
            if (srcRequest !== (srcPending & srcEnable)) begin
                badCount <= badCount + 16'h0001;
            end
        end
    end
endmodule : ipc_arb_model
`default_nettype wire

// file: sim/ipc_priority_regs_tb_top.sv
// testbench of the priority register bank
`timescale 1ns/10ps
`default_nettype none
`include "ipc_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module ipc_priority_regs_tb_top;
    logic sys_clk = 1'b0, rst_b = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [19:0] srcPending, srcEnable, srcRequest;
    logic [39:0] srcLevel;
    logic [15:0] badCount;
    logic [31:0] rdData;
    logic [3:0] wrStrb = 4'hF;
    int err_total = 0, comparisons = 0;
    // implemented bits per register, worked out from the field layout
    logic [15:0] maskTab [4] = '{16'h3C00, 16'h003F, 16'hFFCF, 16'hFFFC};
    ipc_priority_regs ipc_priority_regs_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .srcPending(srcPending),
        .srcEnable(srcEnable), .srcLevel(srcLevel), .srcRequest(srcRequest));
    ipc_arb_model ipc_arb_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .srcEnable(srcEnable),
        .srcRequest(srcRequest), .srcPending(srcPending), .badCount(badCount));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= wrStrb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // each channel is released at its own handshake edge, in either order
        while (!(awDone && wDone)) begin
            @(posedge sys_clk);
            if (!awDone && s_axi_awready === 1'b1) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready === 1'b1) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic report_and_stop;
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reserved;
        for (int i = 0; i < 4; i++) begin
            rd(32'(i * 4), rdData, resp);
            `CHK(rdData, 32'h0000_0000)
            wr(32'(i * 4), 32'hFFFF_FFFF, resp);
            rd(32'(i * 4), rdData, resp);
            `CHK(rdData, {16'h0000, maskTab[i]})
        end
        `CHK(srcEnable, 20'hF_FFFE)
        `CHK(srcLevel[39:2], 38'h3F_FAAA_AAAA)
        for (int i = 0; i < 4; i++) wr(32'(i * 4), 32'h0000_0000, resp);
        `CHK(srcRequest, 20'h0_0000)
    endtask : t_reserved
    task automatic t_field_map;
        int src;
        logic [31:0] d;
        logic [1:0] lv;
        src = 19;
        for (int r = 0; r < 4; r++) for (int lo = 14; lo >= 0; lo -= 2) if (maskTab[r][lo]) begin
            for (int f = 1; f < 4; f++) begin
                d = 32'(f) << lo;
                lv = (src >= 15) ? 2'(f) : 2'(f - 1);
                wr(32'(r * 4), d, resp);
                `CHK(srcEnable, 20'h0_0001 << src)
                `CHK(srcLevel[2*src +: 2], lv)
                rd(32'(r * 4), rdData, resp);
                `CHK(rdData, d)
            end
            wr(32'(r * 4), 32'h0000_0000, resp);
            src--;
        end
        `CHK(src, 0)
    endtask : t_field_map
    task automatic t_bad_addr;
        wr(32'h0000_0010, 32'hFFFF_FFFF, resp);
        `CHK(resp, `IPC_RESP_SLVERR)
        wr(32'h0000_0006, 32'hFFFF_FFFF, resp);
        `CHK(resp, `IPC_RESP_SLVERR)
        rd(32'h0000_0010, rdData, resp);
        `CHK({resp, rdData}, {`IPC_RESP_SLVERR, 32'h0000_0000})
        rd(32'h0000_0004, rdData, resp);
        `CHK({resp, rdData}, {`IPC_RESP_OKAY, 32'h0000_0000})
    endtask : t_bad_addr
    // byte lanes: upper lane then lower lane into the port register
    task automatic t_strobe;
        wrStrb = 4'h2;
        wr(32'h0000_000C, 32'h0000_FFFF, resp);
        `CHK(resp, `IPC_RESP_OKAY)
        `CHK(srcEnable, 20'h0_00F0)
        wrStrb = 4'h1;
        wr(32'h0000_000C, 32'h0000_00FF, resp);
        wrStrb = 4'hF;
        rd(32'h0000_000C, rdData, resp);
        `CHK(rdData, {16'h0000, `IPC_MASK_PORTS})
        `CHK(srcEnable, 20'h0_00FE)
        `CHK(srcLevel[15:2], 14'h2AAA)
        wr(32'h0000_000C, 32'h0000_0000, resp);
    endtask : t_strobe
    task automatic t_mid_reset;
        wr(32'h0000_0008, 32'h0000_FFFF, resp);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(posedge sys_clk);
        rst_b <= 1'b1;
        // registers clear on the reset edge; look one edge later
        @(posedge sys_clk);
        `CHK(srcEnable, 20'h0_0000)
        rd(32'h0000_0008, rdData, resp);
        `CHK(rdData, 32'h0000_0000)
    endtask : t_mid_reset
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reserved();
        t_field_map();
        t_bad_addr();
        t_strobe();
        t_mid_reset();
        `CHK(badCount, 16'h0000)
        report_and_stop();
    end
    // about 500 cycles expected; a stalled handshake ends here
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
endmodule : ipc_priority_regs_tb_top
`default_nettype wire
